//--- hw/cfpr_regs.sv
// clock fault, over-temperature retry, checksum and book select registers
//
// How it works
// - bit3 picks detector b auto or latched
// - bit2 picks detector a auto or latched
// - fault ramps gain down at chosen rate
// - missing clock past timeout mutes playback
// - overtemp retries unless retry disable set
// - running crc8 readable at 0x7e
// - checksum write restarts accumulation
// - book select register at 0x7f
`include "cfpr_cfg.svh"
module cfpr_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register access from the serial-bus front end
  input wire cfpr_pkg::cfpr_req_type req,
  output logic [7:0] rdata,
  input wire cfpr_pkg::cfpr_busbyte_type bus_byte,
  // monitored clocks and events
  input wire logic clk_a_tick,
  input wire logic clk_b_tick,
  input wire logic overtemp,
  input wire logic host_recover,
  // playback control
  output logic playback_mute,
  output logic gain_ramp_step,
  output logic [7:0] ramp_gain_db,
  output logic fault_shutdown,
  output logic overtemp_shutdown,
  output logic [7:0] book_select
);
  timeunit 1ns;
  timeprecision 1ns;
  import cfpr_pkg::*;

  // ----------------------------------------
  // timing tables
  // ----------------------------------------
  localparam int CYC_PER_US = `CFPR_CLK_MHZ;
  localparam int TO_NS [8] = '{`CFPR_TO0_NS, `CFPR_TO1_NS, `CFPR_TO2_NS, `CFPR_TO3_NS,
                                `CFPR_TO4_NS, `CFPR_TO5_NS, `CFPR_TO6_NS, `CFPR_TO7_NS};
  localparam int RAMP_US [4] = '{`CFPR_RAMP0_US, `CFPR_RAMP1_US, `CFPR_RAMP2_US,
                                  `CFPR_RAMP3_US};
  localparam logic [7:0] RAMP_FLOOR_DB = 8'hff;

  // longest timeout needs 19 bits
  function automatic logic [18:0] to_cycles(input logic [2:0] code);
    int c;
    c = (TO_NS[code] * CYC_PER_US) / 1000;
    return 19'(c);
  endfunction

  function automatic logic [13:0] ramp_cycles(input logic [1:0] code);
    return 14'(RAMP_US[code] * CYC_PER_US);
  endfunction

  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `CFPR_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] recovery_r;
  logic [7:0] timing_r;
  logic [7:0] retry_r;
  logic [7:0] checksum_r;
  logic [7:0] book_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      recovery_r <= `CFPR_RST_RECOVERY;
      timing_r <= `CFPR_RST_TIMING;
      retry_r <= `CFPR_RST_RETRY;
      book_r <= `CFPR_RST_BOOK;
    end else if (req.wr) begin
      case (req.addr)
        `CFPR_OFS_RECOVERY: recovery_r <= req.wdata;
        `CFPR_OFS_TIMING: timing_r <= req.wdata;
        `CFPR_OFS_RETRY: retry_r <= req.wdata;
        `CFPR_OFS_BOOK: book_r <= req.wdata;
        default: ;
      endcase
    end
  end

  // running checksum; a write restarts it, ignoring the written value
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      checksum_r <= `CFPR_RST_CHECKSUM;
    end else if (req.wr && req.addr == `CFPR_OFS_CHECKSUM) begin
      checksum_r <= `CFPR_RST_CHECKSUM;
    end else if (bus_byte.byte_valid) begin
      checksum_r <= crc8_step(checksum_r, bus_byte.byte_data);
    end
  end

  // read mux
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        `CFPR_OFS_RECOVERY: rdata <= recovery_r;
        `CFPR_OFS_TIMING: rdata <= timing_r;
        `CFPR_OFS_RETRY: rdata <= retry_r;
        `CFPR_OFS_CHECKSUM: rdata <= checksum_r;
        `CFPR_OFS_BOOK: rdata <= book_r;
        default: rdata <= 8'h00;
      endcase
    end
  end

  assign book_select = book_r;

  // ----------------------------------------
  // clock-loss detectors
  // ----------------------------------------
  logic [18:0] cnt_a_r;
  logic [18:0] cnt_b_r;
  logic lost_a;
  logic lost_b;
  assign lost_a = cnt_a_r >= to_cycles(timing_r[5:3]);
  assign lost_b = cnt_b_r >= to_cycles(timing_r[2:0]);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_a_r <= 19'h00000;
    end else if (clk_a_tick) begin
      cnt_a_r <= 19'h00000;
    end else if (!lost_a) begin
      cnt_a_r <= cnt_a_r + 19'h00001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_b_r <= 19'h00000;
    end else if (clk_b_tick) begin
      cnt_b_r <= 19'h00000;
    end else if (!lost_b) begin
      cnt_b_r <= cnt_b_r + 19'h00001;
    end
  end

  // a latched fault needs policy bit set for the detector that fired
  logic latch_req;
  assign latch_req = (lost_a && recovery_r[`CFPR_BIT_A_POLICY])
                   || (lost_b && recovery_r[`CFPR_BIT_B_POLICY]);

  // ----------------------------------------
  // gain ramp and mute sequencer
  // ----------------------------------------
  cfpr_state_type state_r;
  logic [13:0] step_cnt_r;
  logic [7:0] gain_db_r;
  logic step_done;
  assign step_done = step_cnt_r >= ramp_cycles(timing_r[7:6]) - 14'h0001;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= CFPR_RUN;
    end else begin
      case (state_r)
        CFPR_RUN: if (lost_a || lost_b) state_r <= CFPR_RAMP;
        CFPR_RAMP: if (step_done && gain_db_r == RAMP_FLOOR_DB - 8'h01) state_r <= CFPR_MUTED;
        CFPR_MUTED: begin
          if (latch_req) begin
            state_r <= CFPR_HALTED;
          end else if (!lost_a && !lost_b) begin
            state_r <= CFPR_RUN;
          end
        end
        CFPR_HALTED: if (host_recover && !lost_a && !lost_b) state_r <= CFPR_RUN;
        default: state_r <= CFPR_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      step_cnt_r <= 14'h0000;
      gain_db_r <= 8'h00;
    end else if (state_r == CFPR_RAMP) begin
      if (step_done) begin
        step_cnt_r <= 14'h0000;
        gain_db_r <= gain_db_r + 8'h01;
      end else begin
        step_cnt_r <= step_cnt_r + 14'h0001;
      end
    end else if (state_r == CFPR_RUN) begin
      step_cnt_r <= 14'h0000;
      gain_db_r <= 8'h00;
    end
  end

  assign gain_ramp_step = (state_r == CFPR_RAMP) && step_done;
  assign ramp_gain_db = gain_db_r;
  assign playback_mute = (state_r == CFPR_MUTED) || (state_r == CFPR_HALTED);
  assign fault_shutdown = (state_r == CFPR_HALTED);

  // ----------------------------------------
  // over-temperature retry
  // ----------------------------------------
  logic ot_latched_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ot_latched_r <= 1'b0;
    end else if (overtemp) begin
      ot_latched_r <= 1'b1;
    end else if (!retry_r[`CFPR_BIT_OT_RETRY_DIS] || host_recover) begin
      ot_latched_r <= 1'b0;
    end
  end
  assign overtemp_shutdown = ot_latched_r;
endmodule

//--- hw/cfpr_cfg.svh
// register offsets, field positions, reset values and timings in ns and us
`ifndef CFPR_CFG_SVH
`define CFPR_CFG_SVH
`define CFPR_OFS_RECOVERY 8'h4f
`define CFPR_OFS_TIMING 8'h50
`define CFPR_OFS_RETRY 8'h58
`define CFPR_OFS_CHECKSUM 8'h7e
`define CFPR_OFS_BOOK 8'h7f
`define CFPR_RST_RECOVERY 8'h00
`define CFPR_RST_TIMING 8'h11
`define CFPR_RST_RETRY 8'h03
`define CFPR_RST_CHECKSUM 8'h00
`define CFPR_RST_BOOK 8'h00
`define CFPR_BIT_A_POLICY 2
`define CFPR_BIT_B_POLICY 3
`define CFPR_BIT_OT_RETRY_DIS 2
`define CFPR_CLK_MHZ 100
// timeouts in ns, as printed (10.6 us .. 2.73 ms)
`define CFPR_TO0_NS 10600
`define CFPR_TO1_NS 21300
`define CFPR_TO2_NS 42600
`define CFPR_TO3_NS 85300
`define CFPR_TO4_NS 340000
`define CFPR_TO5_NS 680000
`define CFPR_TO6_NS 1360000
`define CFPR_TO7_NS 2730000
// ramp rates in us per dB
`define CFPR_RAMP0_US 15
`define CFPR_RAMP1_US 30
`define CFPR_RAMP2_US 60
`define CFPR_RAMP3_US 120
`define CFPR_CRC_POLY 8'h07
`endif

//--- hw/cfpr_pkg.sv
// types shared by the clock fault protection register block
package cfpr_pkg;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfpr_req_type;
  typedef struct packed {
    logic byte_valid;
    logic [7:0] byte_data;
  } cfpr_busbyte_type;
  typedef enum logic [1:0] {CFPR_RUN, CFPR_RAMP, CFPR_MUTED, CFPR_HALTED} cfpr_state_type;
endpackage

//--- verif/cfpr_regs_properties.sv
// port checks for the clock fault register block
module cfpr_regs_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // watched ports
  input wire cfpr_pkg::cfpr_req_type req,
  input wire logic [7:0] rdata,
  input wire cfpr_pkg::cfpr_busbyte_type bus_byte,
  input wire logic overtemp,
  input wire logic host_recover,
  input wire logic playback_mute,
  input wire logic gain_ramp_step,
  input wire logic [7:0] ramp_gain_db,
  input wire logic fault_shutdown,
  input wire logic overtemp_shutdown,
  input wire logic [7:0] book_select
);
  timeunit 1ns;
  timeprecision 1ns;
  import cfpr_pkg::*;
  // ---
  // properties
  // ---
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_book_write: assert property (req.wr && req.addr == 8'h7f |=> book_select == $past(req.wdata))
    else $error("book write lost");
  a_book_hold: assert property (!(req.wr && req.addr == 8'h7f) |=> $stable(book_select))
    else $error("book changed");
  a_book_read: assert property (req.rd && !req.wr && req.addr == 8'h7f |=> rdata == book_select)
    else $error("book readback");
  a_crc_restart: assert property (req.wr && req.addr == 8'h7e ##1 !bus_byte.byte_valid
    ##1 bus_byte == 9'h17e ##1 req.rd && !req.wr && req.addr == 8'h7e && !bus_byte.byte_valid
    |=> rdata == 8'h7d) else $error("checksum restart");
  a_ot_set: assert property (overtemp |=> overtemp_shutdown)
    else $error("overtemp no shutdown");
  a_gain_step: assert property (gain_ramp_step |=> ramp_gain_db == $past(ramp_gain_db) + 8'h01)
    else $error("ramp step size");
  a_step_gap: assert property (gain_ramp_step |=> !gain_ramp_step [*8])
    else $error("ramp steps too close");
  a_mute_full: assert property ($rose(playback_mute) |-> ramp_gain_db == 8'hff)
    else $error("mute before ramp end");
  a_halt_hold: assert property (fault_shutdown && !host_recover |=> fault_shutdown && playback_mute)
    else $error("halt released");
endmodule

//--- verif/cfpr_host_model.sv
// host model: register requests with their serial-bus bytes
module cfpr_host_model (
  // clock
  input wire logic ref_clk,
  // host side
  output cfpr_pkg::cfpr_req_type req,
  output cfpr_pkg::cfpr_busbyte_type bus_byte,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import cfpr_pkg::*;
  logic [7:0] crc_exp = 8'h00;
  initial req = '0;
  initial bus_byte = '0;
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  task automatic cyc(input cfpr_req_type r, input logic bv, input logic [7:0] bd);
    @(posedge ref_clk);
    req <= r;
    bus_byte <= '{bv, bd};
    if (bv) crc_exp = crc8(crc_exp, bd);
    if (r.wr && r.addr == 8'h7e) crc_exp = 8'h00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc('0, 1'b1, a);
    cyc('0, 1'b1, d);
    cyc('{1'b1, 1'b0, a, d}, 1'b0, 8'h00);
    cyc('0, 1'b0, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [7:0] c);
    cyc('0, 1'b1, a);
    cyc('{1'b0, 1'b1, a, 8'h00}, 1'b0, 8'h00);
    cyc('0, 1'b0, 8'h00);
    #1;
    c = crc_exp;
    v = rdata;
    cyc('0, 1'b1, v);
    cyc('0, 1'b0, 8'h00);
  endtask
endmodule

//--- verif/tb_cfpr_regs.sv
// self-checking bench for the clock fault register block
module tb_cfpr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import cfpr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic tick_on = 1'b1;
  logic clk_a_tick = 1'b0;
  logic clk_b_tick = 1'b0;
  logic overtemp = 1'b0;
  logic host_recover = 1'b0;
  cfpr_req_type req;
  cfpr_busbyte_type bus_byte;
  logic [7:0] rdata, ramp_gain_db, book_select, v, c;
  logic playback_mute, gain_ramp_step, fault_shutdown, overtemp_shutdown;
  logic [7:0] ofs [5] = '{8'h4f, 8'h50, 8'h58, 8'h7f, 8'h00};
  logic [7:0] rv [5] = '{8'h00, 8'h11, 8'h03, 8'h00, 8'h00};
  logic [7:0] wv [2] = '{8'hff, 8'h00};
  int n_mismatch = 0;
  int comparisons = 0;
  int n_steps = 0;
  always #5 ref_clk = ~ref_clk;
  // counts ramp step pulses seen by the bench
  always @(posedge ref_clk) begin
    if (gain_ramp_step === 1'b1) n_steps++;
  end
  always @(posedge ref_clk) begin
    clk_a_tick <= tick_on & ~clk_a_tick;
    clk_b_tick <= tick_on & ~clk_b_tick;
  end
  cfpr_regs u_dut (.ref_clk, .rst_b, .req, .rdata, .bus_byte, .clk_a_tick, .clk_b_tick,
    .overtemp, .host_recover, .playback_mute, .gain_ramp_step, .ramp_gain_db,
    .fault_shutdown, .overtemp_shutdown, .book_select);
  cfpr_host_model u_host (.ref_clk, .req, .bus_byte, .rdata);
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ---
  // tests
  // ---
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      u_host.rd(ofs[i], v, c);
      check("reset value", v, rv[i]);
    end
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 5; i++) begin
        u_host.wr(ofs[i], wv[j]);
        u_host.rd(ofs[i], v, c);
        check("written value", v, (i == 4) ? 8'h00 : wv[j]);
        if (i == 3) check("book select", book_select, wv[j]);
      end
      @(posedge ref_clk) overtemp <= 1'b1;
      @(posedge ref_clk) overtemp <= 1'b0;
      #1 check("overtemp set", {7'h00, overtemp_shutdown}, 8'h01);
      repeat (2) @(posedge ref_clk);
      #1 check("overtemp retry", {7'h00, overtemp_shutdown}, {7'h00, wv[j][2]});
      @(posedge ref_clk) host_recover <= 1'b1;
      @(posedge ref_clk) host_recover <= 1'b0;
      #1 check("overtemp recover", {7'h00, overtemp_shutdown}, 8'h00);
    end
    u_host.wr(8'h7e, 8'h3c);
    for (int k = 0; k < 3; k++) begin
      u_host.rd(8'h7e, v, c);
      check("checksum", v, c);
    end
    tick_on <= 1'b0;
    // timeout 1060 cycles, then 1500 cycles per step at code 0
    repeat (2555) @(posedge ref_clk);
    #1 check("gain before step", ramp_gain_db, 8'h00);
    repeat (10) @(posedge ref_clk);
    #1 check("gain after step", ramp_gain_db, 8'h01);
    check("mute in ramp", {7'h00, playback_mute}, 8'h00);
    repeat (1500) @(posedge ref_clk);
    #1 check("gain second step", ramp_gain_db, 8'h02);
    check("ramp steps", 8'(n_steps), 8'h02);
    check("no shutdown in ramp", {7'h00, fault_shutdown}, 8'h00);
    tally_and_finish();
  end
  initial begin
    repeat (10000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
bind cfpr_regs cfpr_regs_properties u_props (.ref_clk, .rst_b, .req, .rdata, .bus_byte,
  .overtemp, .host_recover, .playback_mute, .gain_ramp_step, .ramp_gain_db,
  .fault_shutdown, .overtemp_shutdown, .book_select);
